/* include/ddsagu_pkg.sv */
// Shared constants for the dual data space address generation block.
// Assumes a 16-bit byte-addressed data space and a 32-bit Avalon-MM register port.
package ddsagu_pkg;
   // Widths and fixed configuration
   localparam int AW = 16;
   localparam int IDXW = 4;
   localparam int RIDXW = 4;
   localparam logic [15:0] XY_BOUNDARY_DEF = 16'h4000;
   localparam logic [3:0] STACK_PTR_IDX = 4'hF;
   localparam logic [15:0] WORD_STEP = 16'h0002;
   localparam logic [15:0] BYTE_STEP = 16'h0001;

   // Register word indices, byte address is four times the index
   localparam logic [3:0] REG_MODE = 4'h0;
   localparam logic [3:0] REG_X_START = 4'h1;
   localparam logic [3:0] REG_X_END = 4'h2;
   localparam logic [3:0] REG_Y_START = 4'h3;
   localparam logic [3:0] REG_Y_END = 4'h4;
   localparam logic [3:0] REG_BITREV = 4'h5;
   localparam logic [3:0] REG_STATUS = 4'h6;
   localparam logic [3:0] REG_CONFIG = 4'h7;

   // Mode control fields
   localparam int MODE_XSEL_LSB = 0;
   localparam int MODE_YSEL_LSB = 4;
   localparam int MODE_BRSEL_LSB = 8;
   localparam int MODE_YEN_BIT = 14;
   localparam int MODE_XEN_BIT = 15;
   // Bit-reversal register fields
   localparam int BR_EN_BIT = 15;
   localparam int BR_MOD_MSB = 14;
   // Status fields
   localparam int ST_BR_BIT = 16;
   localparam int ST_XWRAP_BIT = 17;
   localparam int ST_YWRAP_BIT = 18;
   localparam int ST_YOUT_BIT = 19;
   localparam int CFG_DSP_BIT = 16;

   // Reset values
   localparam logic [15:0] MODE_RST = 16'h0FFF;
   localparam logic [15:0] START_RST = 16'h0000;
   localparam logic [15:0] END_RST = 16'hFFFF;
   localparam logic [15:0] BITREV_RST = 16'h0000;

   // Addressing modes presented by instruction decode
   typedef enum logic [2:0] {
      AM_PLAIN = 3'h0,
      AM_POST_INC = 3'h1,
      AM_POST_DEC = 3'h2,
      AM_PRE_INC = 3'h3,
      AM_PRE_DEC = 3'h4,
      AM_REG_OFS = 3'h5
   } ddsagu_am_t;

   // Register port handshake states
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b01,
      BUS_ACK = 2'b10
   } ddsagu_bus_t;
endpackage

/* hdl/ddsagu_unit.sv */
// One address generation unit: effective address, pointer update,
// modulo wrap and, where built in, bit-reversed write addressing.
// Purely combinational; the caller registers every result.
`timescale 1ns/1ns
module ddsagu_unit #(
   parameter bit HAS_BITREV = 1'b1,
   parameter bit DSP = 1'b1
) (
   input wire logic req,
   input wire logic [3:0] ptr_idx,
   input wire logic [2:0] am,
   input wire logic wr,
   input wire logic byte_sz,
   input wire logic [15:0] ptr,
   input wire logic [15:0] ofs,
   input wire logic mod_en,
   input wire logic [3:0] mod_sel,
   input wire logic [15:0] mod_start,
   input wire logic [15:0] mod_end,
   input wire logic br_en,
   input wire logic [3:0] br_sel,
   input wire logic [14:0] br_mod,
   output logic [15:0] ea,
   output logic [15:0] new_ptr,
   output logic wb_en,
   output logic wrapped,
   output logic br_used
);
   // Add with carry running from the top bit downward
   function automatic logic [15:0] rev_add(input logic [15:0] a, input logic [15:0] b);
      logic c;
      logic [15:0] s;
      c = 1'b0;
      s = 16'h0000;
      for (int i = 15; i >= 0; i--) begin
         s[i] = a[i] ^ b[i] ^ c;
         c = (a[i] & b[i]) | (c & (a[i] ^ b[i]));
      end
      return s;
   endfunction

   // Mode decode
   wire is_inc = (am == ddsagu_pkg::AM_POST_INC) || (am == ddsagu_pkg::AM_PRE_INC);
   wire is_dec = (am == ddsagu_pkg::AM_POST_DEC) || (am == ddsagu_pkg::AM_PRE_DEC);
   wire is_pre = (am == ddsagu_pkg::AM_PRE_INC) || (am == ddsagu_pkg::AM_PRE_DEC);
   wire is_ofs = (am == ddsagu_pkg::AM_REG_OFS);
   wire [15:0] step = byte_sz ? ddsagu_pkg::BYTE_STEP : ddsagu_pkg::WORD_STEP;

   // Target before any correction
   wire [15:0] target = is_ofs ? ptr + ofs : is_inc ? ptr + step : is_dec ? ptr - step : ptr;
   wire up = is_inc | (is_ofs & ~ofs[15]);
   wire down = is_dec | (is_ofs & ofs[15]);

   // Modulo wrap on overshoot in either direction
   wire mod_on = DSP && mod_en && (mod_sel == ptr_idx);
   wire [15:0] len = mod_end - mod_start + 16'h0001;
   wire over = up && (target > mod_end);
   wire under = down && (target < mod_start);
   wire [15:0] corr = !mod_on ? target : over ? target - len : under ? target + len : target;

   // Bit-reversed writes: X only, word writes, incrementing modes
   wire br_on = HAS_BITREV && DSP && br_en && (br_sel != ddsagu_pkg::STACK_PTR_IDX)
                && (br_sel == ptr_idx) && wr && !byte_sz && is_inc;
   wire [15:0] br_new = rev_add({ptr[15:1], 1'b0}, {br_mod, 1'b0}) & 16'hFFFE;

   // Results, bit reversal taking precedence over modulo
   assign new_ptr = br_on ? br_new : corr;
   assign ea = br_on ? (is_pre ? br_new : {ptr[15:1], 1'b0})
             : (is_pre | is_ofs) ? corr : ptr;
   assign wb_en = req & (is_inc | is_dec);
   assign wrapped = req & mod_on & !br_on & (over | under);
   assign br_used = req & br_on;
endmodule

/* hdl/ddsagu_top.sv */
// Top of the dual data space address generation block.
// Assumes decode presents requests one cycle ahead of the RAM, and an Avalon-MM master.
//
// The address map and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/1ns
module ddsagu_top #(
   parameter logic [15:0] XY_BOUNDARY = ddsagu_pkg::XY_BOUNDARY_DEF,
   parameter bit DSP = 1'b1
) (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic ce,
   // Register port
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // X request from decode
   input wire logic x_req,
   input wire logic [3:0] x_ptr_idx,
   input wire logic [2:0] x_am,
   input wire logic x_wr,
   input wire logic x_byte,
   input wire logic [15:0] x_ptr,
   input wire logic [15:0] x_ofs,
   input wire logic [15:0] x_wdata,
   // Y request from decode, reads only
   input wire logic y_req,
   input wire logic [3:0] y_ptr_idx,
   input wire logic [2:0] y_am,
   input wire logic [15:0] y_ptr,
   input wire logic [15:0] y_ofs,
   // Data RAM side
   output logic [15:0] x_addr,
   output logic x_rd,
   output logic x_wr_en,
   output logic x_byte_en,
   output logic [15:0] x_wr_data,
   output logic [15:0] y_addr,
   output logic y_rd,
   // Pointer write-back to working registers
   output logic x_wb_en,
   output logic [3:0] x_wb_idx,
   output logic [15:0] x_wb_val,
   output logic y_wb_en,
   output logic [3:0] y_wb_idx,
   output logic [15:0] y_wb_val
);
   // Elaboration check: the X/Y boundary must sit on a word
   if (XY_BOUNDARY[0] != 1'b0) begin : g_bad_boundary
      $error("XY_BOUNDARY must be word aligned");
   end

   // Software-visible control
   logic [15:0] mode_q, mode_d;
   logic [15:0] xs_q, xs_d, xe_q, xe_d, ys_q, ys_d, ye_q, ye_d;
   logic [15:0] br_q, br_d;
   logic [3:0] stat_q, stat_d;
   ddsagu_pkg::ddsagu_bus_t bus_q, bus_d;

   // Per-unit request arrays, index 0 is X, 1 is Y
   logic [1:0] u_req, u_wr, u_byte, u_men, u_wb, u_wrap, u_br;
   logic [3:0] u_idx [2];
   logic [3:0] u_msel [2];
   logic [2:0] u_am [2];
   logic [15:0] u_ptr [2];
   logic [15:0] u_ofs [2];
   logic [15:0] u_ms [2];
   logic [15:0] u_me [2];
   logic [15:0] u_ea [2];
   logic [15:0] u_np [2];

   // Request fan-in; Y unit never writes
   assign u_req = {y_req, x_req};
   assign u_wr = {1'b0, x_wr};
   assign u_byte = {1'b0, x_byte};
   assign u_men = {mode_q[ddsagu_pkg::MODE_YEN_BIT], mode_q[ddsagu_pkg::MODE_XEN_BIT]};
   assign u_idx[0] = x_ptr_idx;
   assign u_idx[1] = y_ptr_idx;
   assign u_am[0] = x_am;
   assign u_am[1] = y_am;
   assign u_ptr[0] = x_ptr;
   assign u_ptr[1] = y_ptr;
   assign u_ofs[0] = x_ofs;
   assign u_ofs[1] = y_ofs;
   assign u_msel[0] = mode_q[ddsagu_pkg::MODE_XSEL_LSB +: 4];
   assign u_msel[1] = mode_q[ddsagu_pkg::MODE_YSEL_LSB +: 4];
   assign u_ms[0] = xs_q;
   assign u_ms[1] = ys_q;
   assign u_me[0] = xe_q;
   assign u_me[1] = ye_q;

   // One address unit per space, bit reversal built only into X
   for (genvar u = 0; u < 2; u++) begin : g_unit
      ddsagu_unit #(
         .HAS_BITREV(u == 0),
         .DSP(DSP)
      ) i_unit (
         .req(u_req[u]),
         .ptr_idx(u_idx[u]),
         .am(u_am[u]),
         .wr(u_wr[u]),
         .byte_sz(u_byte[u]),
         .ptr(u_ptr[u]),
         .ofs(u_ofs[u]),
         .mod_en(u_men[u]),
         .mod_sel(u_msel[u]),
         .mod_start(u_ms[u]),
         .mod_end(u_me[u]),
         .br_en(br_q[ddsagu_pkg::BR_EN_BIT]),
         .br_sel(mode_q[ddsagu_pkg::MODE_BRSEL_LSB +: 4]),
         .br_mod(br_q[ddsagu_pkg::BR_MOD_MSB:0]),
         .ea(u_ea[u]),
         .new_ptr(u_np[u]),
         .wb_en(u_wb[u]),
         .wrapped(u_wrap[u]),
         .br_used(u_br[u])
      );
   end

   // Y access falling below the fixed boundary
   wire y_out = y_req && (u_ea[1] < XY_BOUNDARY);

   // RAM address, strobe and write data registers
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         x_addr <= 16'h0000;
         x_rd <= 1'b0;
         x_wr_en <= 1'b0;
         x_byte_en <= 1'b0;
         x_wr_data <= 16'h0000;
         y_addr <= 16'h0000;
         y_rd <= 1'b0;
      end else if (ce) begin
         x_addr <= u_ea[0];
         x_rd <= x_req & ~x_wr;
         x_wr_en <= x_req & x_wr;
         x_byte_en <= x_byte;
         x_wr_data <= x_wdata;
         y_addr <= u_ea[1];
         y_rd <= y_req;
      end
   end

   // Pointer updates back to the working registers
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         x_wb_en <= 1'b0;
         x_wb_idx <= 4'h0;
         x_wb_val <= 16'h0000;
         y_wb_en <= 1'b0;
         y_wb_idx <= 4'h0;
         y_wb_val <= 16'h0000;
      end else if (ce) begin
         x_wb_en <= u_wb[0];
         x_wb_idx <= x_ptr_idx;
         x_wb_val <= u_np[0];
         y_wb_en <= u_wb[1];
         y_wb_idx <= y_ptr_idx;
         y_wb_val <= u_np[1];
      end
   end

   // Register port decode
   wire bus_req = avs_read | avs_write;
   wire take = (bus_q == ddsagu_pkg::BUS_IDLE) && bus_req;
   wire wr_take = take && avs_write;
   wire [15:0] be_mask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
   wire [15:0] wd = avs_writedata[15:0];
   wire w_mode = wr_take && (avs_address == ddsagu_pkg::REG_MODE);
   wire w_xs = wr_take && (avs_address == ddsagu_pkg::REG_X_START);
   wire w_xe = wr_take && (avs_address == ddsagu_pkg::REG_X_END);
   wire w_ys = wr_take && (avs_address == ddsagu_pkg::REG_Y_START);
   wire w_ye = wr_take && (avs_address == ddsagu_pkg::REG_Y_END);
   wire w_br = wr_take && (avs_address == ddsagu_pkg::REG_BITREV);

   // Byte-lane merge of written registers; DSP-less build keeps them at reset
   assign mode_d = (w_mode && DSP) ? (mode_q & ~be_mask) | (wd & be_mask) : mode_q;
   assign xs_d = (w_xs && DSP) ? (xs_q & ~be_mask) | (wd & be_mask) : xs_q;
   assign xe_d = (w_xe && DSP) ? (xe_q & ~be_mask) | (wd & be_mask) : xe_q;
   assign ys_d = (w_ys && DSP) ? (ys_q & ~be_mask) | (wd & be_mask) : ys_q;
   assign ye_d = (w_ye && DSP) ? (ye_q & ~be_mask) | (wd & be_mask) : ye_q;
   assign br_d = (w_br && DSP) ? (br_q & ~be_mask) | (wd & be_mask) : br_q;

   // Status of the last address cycle
   assign stat_d = (x_req | y_req) ? {y_out, u_wrap[1], u_wrap[0], u_br[0]} : stat_q;

   // Read mux; boundary is a constant, unmapped reads return zero
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0000_0000;
      case (avs_address)
         ddsagu_pkg::REG_MODE: rd_mux = {16'h0000, mode_q};
         ddsagu_pkg::REG_X_START: rd_mux = {16'h0000, xs_q};
         ddsagu_pkg::REG_X_END: rd_mux = {16'h0000, xe_q};
         ddsagu_pkg::REG_Y_START: rd_mux = {16'h0000, ys_q};
         ddsagu_pkg::REG_Y_END: rd_mux = {16'h0000, ye_q};
         ddsagu_pkg::REG_BITREV: rd_mux = {16'h0000, br_q};
         ddsagu_pkg::REG_STATUS: rd_mux = {12'h000, stat_q, x_addr};
         ddsagu_pkg::REG_CONFIG: rd_mux = {15'h0000, DSP, XY_BOUNDARY};
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // Handshake: one wait cycle, then a single answer cycle
   always_comb begin
      case (bus_q)
         ddsagu_pkg::BUS_IDLE: bus_d = take ? ddsagu_pkg::BUS_ACK : ddsagu_pkg::BUS_IDLE;
         ddsagu_pkg::BUS_ACK: bus_d = ddsagu_pkg::BUS_IDLE;
         default: bus_d = ddsagu_pkg::BUS_IDLE;
      endcase
   end

   // Control registers
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         mode_q <= ddsagu_pkg::MODE_RST;
         xs_q <= ddsagu_pkg::START_RST;
         xe_q <= ddsagu_pkg::END_RST;
         ys_q <= ddsagu_pkg::START_RST;
         ye_q <= ddsagu_pkg::END_RST;
         br_q <= ddsagu_pkg::BITREV_RST;
         stat_q <= 4'h0;
      end else if (ce) begin
         mode_q <= mode_d;
         xs_q <= xs_d;
         xe_q <= xe_d;
         ys_q <= ys_d;
         ye_q <= ye_d;
         br_q <= br_d;
         stat_q <= stat_d;
      end
   end

   // Bus state and answer
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         bus_q <= ddsagu_pkg::BUS_IDLE;
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h0000_0000;
      end else if (ce) begin
         bus_q <= bus_d;
         avs_waitrequest <= ~take;
         if (take && avs_read) begin
            avs_readdata <= rd_mux;
         end
      end
   end

   // Checks
   a_bitrev_x_only: assert property (@(posedge core_clk) disable iff (!rstn)
      u_br[0] |-> x_wr && !x_byte && (x_am == ddsagu_pkg::AM_PRE_INC
      || x_am == ddsagu_pkg::AM_POST_INC))
      else $error("bit reversal outside word increment write");
   a_bitrev_no_stack: assert property (@(posedge core_clk) disable iff (!rstn)
      u_br[0] |-> mode_q[ddsagu_pkg::MODE_BRSEL_LSB +: 4] != ddsagu_pkg::STACK_PTR_IDX
      && br_q[ddsagu_pkg::BR_EN_BIT])
      else $error("bit reversal on stack or while disabled");
   a_bitrev_lsb_clear: assert property (@(posedge core_clk) disable iff (!rstn)
      (ce && u_br[0]) |=> x_wb_val[0] == 1'b0 && x_addr[0] == 1'b0)
      else $error("bit reversed address has bit 0 set");
   a_offset_no_wb: assert property (@(posedge core_clk) disable iff (!rstn)
      (ce && x_req && x_am == ddsagu_pkg::AM_REG_OFS) |=> !x_wb_en)
      else $error("register offset mode wrote the pointer back");
   a_premod_wb: assert property (@(posedge core_clk) disable iff (!rstn)
      (ce && y_req && y_am == ddsagu_pkg::AM_PRE_INC) |=> y_wb_en && y_wb_val == y_addr)
      else $error("pre-increment did not write back the address used");
   a_wrap_upper: assert property (@(posedge core_clk) disable iff (!rstn)
      (ce && u_wrap[0] && (x_am == ddsagu_pkg::AM_POST_INC)) |=> x_wb_val <= $past(xe_q)
      && x_wb_val >= $past(xs_q))
      else $error("incrementing wrap left the buffer");
   a_wrap_lower: assert property (@(posedge core_clk) disable iff (!rstn)
      (ce && u_wrap[1] && (y_am == ddsagu_pkg::AM_POST_DEC)) |=> y_wb_val >= $past(ys_q))
      else $error("decrementing wrap fell below the buffer");
   a_bitrev_over_mod: assert property (@(posedge core_clk) disable iff (!rstn)
      u_br[0] |-> !u_wrap[0])
      else $error("modulo acted on a bit reversed write");
   a_no_dsp_plain: assert property (@(posedge core_clk) disable iff (!rstn)
      (u_wrap != 2'b00 || u_br != 2'b00) |-> DSP)
      else $error("DSP addressing active in reduced build");
   a_y_no_write: assert property (@(posedge core_clk) disable iff (!rstn)
      (ce && y_req && !x_req) |=> y_rd && !x_wr_en)
      else $error("Y access produced a write");
   a_bus_answer: assert property (@(posedge core_clk) disable iff (!rstn)
      (ce && take) |=> !avs_waitrequest ##1 avs_waitrequest)
      else $error("register port answer not one cycle");

   // Strobe, write-back and status timing
   a_read_strobe: assert property (@(posedge core_clk) disable iff (!rstn)
      (ce && x_req && !x_wr) |=> x_rd && !x_wr_en)
      else $error("X read request gave no read strobe");
   a_write_strobe: assert property (@(posedge core_clk) disable iff (!rstn)
      (ce && x_req && x_wr) |=> x_wr_en && !x_rd && x_wr_data == $past(x_wdata))
      else $error("X write request gave no write strobe or wrong data");
   a_dual_read: assert property (@(posedge core_clk) disable iff (!rstn)
      (ce && x_req && y_req && !x_wr) |=> x_rd && y_rd)
      else $error("X and Y reads not issued together");
   a_plain_no_wb: assert property (@(posedge core_clk) disable iff (!rstn)
      (ce && x_req && x_am == ddsagu_pkg::AM_PLAIN) |=> !x_wb_en)
      else $error("plain indirect mode wrote the pointer back");
   a_pre_ea_ptr: assert property (@(posedge core_clk) disable iff (!rstn)
      (ce && x_req && (x_am == ddsagu_pkg::AM_PRE_INC || x_am == ddsagu_pkg::AM_PRE_DEC))
      |=> x_wb_en && x_addr == x_wb_val)
      else $error("pre-modify address differs from the written-back pointer");
   a_wb_index: assert property (@(posedge core_clk) disable iff (!rstn)
      (ce && x_req) |=> x_wb_idx == $past(x_ptr_idx))
      else $error("write-back went to another register");
   a_ofs_wrapped: assert property (@(posedge core_clk) disable iff (!rstn)
      (ce && u_wrap[0] && x_am == ddsagu_pkg::AM_REG_OFS) |=> x_addr >= $past(xs_q)
      && x_addr <= $past(xe_q))
      else $error("register offset access left the buffer");
   a_config_fixed: assert property (@(posedge core_clk) disable iff (!rstn)
      (ce && take && avs_read && avs_address == ddsagu_pkg::REG_CONFIG)
      |=> avs_readdata == {15'h0000, DSP, XY_BOUNDARY})
      else $error("configuration word changed");
   a_status_bitrev: assert property (@(posedge core_clk) disable iff (!rstn)
      (ce && u_br[0]) |=> stat_q[0])
      else $error("status missed a bit reversed write");

   c_dual_read: cover property (@(posedge core_clk) disable iff (!rstn) x_rd && y_rd);
   c_bitrev: cover property (@(posedge core_clk) disable iff (!rstn) u_br[0]);
   c_x_wrap: cover property (@(posedge core_clk) disable iff (!rstn) u_wrap[0]);
   c_y_wrap: cover property (@(posedge core_clk) disable iff (!rstn) u_wrap[1]);
   c_y_alone: cover property (@(posedge core_clk) disable iff (!rstn) y_rd && !x_rd);
endmodule

/* sim/ddsagu_ram_model.sv */
// Data RAM model on the far side of the address block.
// Assumes one word per byte address key; X and Y share one array.
`timescale 1ns/1ns
module ddsagu_ram_model (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic [15:0] x_addr,
   input wire logic x_rd,
   input wire logic x_wr_en,
   input wire logic [15:0] x_wr_data,
   input wire logic [15:0] y_addr,
   input wire logic y_rd,
   output logic [15:0] x_q,
   output logic [15:0] y_q,
   output logic [31:0] n_bad
);
   logic [15:0] mem [65536];

   // One combined space takes every write, both paths read it
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         n_bad <= 32'h0;
         x_q <= 16'hFFFF;
         y_q <= 16'hFFFF;
      end else begin
         if (x_wr_en) mem[x_addr] <= x_wr_data;
         if (x_rd && x_wr_en) n_bad <= n_bad + 32'h1; // One direction per access
         x_q <= x_rd ? mem[x_addr] : ~x_q;
         y_q <= y_rd ? mem[y_addr] : ~y_q;
      end
   end
endmodule

/* sim/tb_top.sv */
// Self-checking bench for the dual data space address block.
// Assumes decode and register master are played by this bench.
`timescale 1ns/1ns
module tb_top;
   typedef struct packed {
      logic [3:0] i;
      logic [2:0] am;
      logic w;
      logic b;
      logic [15:0] p;
      logic [15:0] o;
      logic [15:0] ea;
      logic we;
      logic [15:0] nv;
   } ddsagu_tb_row_t;
   logic core_clk = 1'h0;
   logic rstn = 1'h0;
   logic ce = 1'h1;
   logic avs_read, avs_write, avs_waitrequest, x_req, x_wr, x_byte, y_req;
   logic x_rd, x_wr_en, x_byte_en, y_rd, x_wb_en, y_wb_en;
   logic [2:0] x_am, y_am;
   logic [3:0] avs_address, avs_byteenable, x_ptr_idx, y_ptr_idx, x_wb_idx, y_wb_idx;
   logic [15:0] x_ptr, x_ofs, x_wdata, y_ptr, y_ofs, x_addr, x_wr_data, y_addr;
   logic [15:0] x_wb_val, y_wb_val;
   logic [31:0] avs_writedata, avs_readdata, rd, n_bad;
   int n_fail = 0;
   int checks = 0;
   // Rows: idx, mode, write, byte, ptr, ofs, address, write-back, new pointer
   ddsagu_tb_row_t rows [15] = '{
      '{4'h2, 3'h1, 1'h0, 1'h0, 16'h100E, 16'h0000, 16'h100E, 1'h1, 16'h1000},
      '{4'h2, 3'h4, 1'h0, 1'h0, 16'h1000, 16'h0000, 16'h100E, 1'h1, 16'h100E},
      '{4'h2, 3'h5, 1'h0, 1'h0, 16'h1008, 16'h0014, 16'h100C, 1'h0, 16'h0000},
      '{4'h2, 3'h2, 1'h0, 1'h0, 16'h1000, 16'h0000, 16'h1000, 1'h1, 16'h100E},
      '{4'h2, 3'h5, 1'h0, 1'h0, 16'h1002, 16'hFFF8, 16'h100A, 1'h0, 16'h0000},
      '{4'h5, 3'h1, 1'h0, 1'h0, 16'h100E, 16'h0000, 16'h100E, 1'h1, 16'h1010},
      '{4'h2, 3'h0, 1'h0, 1'h0, 16'h1234, 16'h0000, 16'h1234, 1'h0, 16'h0000},
      '{4'h2, 3'h3, 1'h1, 1'h1, 16'h100E, 16'h0000, 16'h100F, 1'h1, 16'h100F},
      '{4'hF, 3'h1, 1'h1, 1'h0, 16'h2000, 16'h0000, 16'h2000, 1'h1, 16'h2002},
      '{4'h2, 3'h1, 1'h1, 1'h0, 16'h100D, 16'h0040, 16'h100C, 1'h1, 16'h1002},
      '{4'h2, 3'h3, 1'h1, 1'h0, 16'h1008, 16'h0000, 16'h1004, 1'h1, 16'h1004},
      '{4'h2, 3'h1, 1'h0, 1'h0, 16'h1004, 16'h0000, 16'h1004, 1'h1, 16'h1006},
      '{4'h2, 3'h1, 1'h1, 1'h1, 16'h1004, 16'h0000, 16'h1004, 1'h1, 16'h1005},
      '{4'h2, 3'h2, 1'h1, 1'h0, 16'h1004, 16'h0000, 16'h1004, 1'h1, 16'h1002},
      '{4'h2, 3'h1, 1'h1, 1'h0, 16'h1004, 16'h0000, 16'h1004, 1'h1, 16'h1006}
   };

   always #5 core_clk = ~core_clk;

   ddsagu_top #(.XY_BOUNDARY(16'h4000), .DSP(1'h1)) dut_u (
      .core_clk(core_clk), .rstn(rstn), .ce(ce), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .x_req(x_req), .x_ptr_idx(x_ptr_idx),
      .x_am(x_am), .x_wr(x_wr), .x_byte(x_byte), .x_ptr(x_ptr), .x_ofs(x_ofs),
      .x_wdata(x_wdata), .y_req(y_req), .y_ptr_idx(y_ptr_idx), .y_am(y_am),
      .y_ptr(y_ptr), .y_ofs(y_ofs), .x_addr(x_addr), .x_rd(x_rd), .x_wr_en(x_wr_en),
      .x_byte_en(x_byte_en), .x_wr_data(x_wr_data), .y_addr(y_addr), .y_rd(y_rd),
      .x_wb_en(x_wb_en), .x_wb_idx(x_wb_idx), .x_wb_val(x_wb_val), .y_wb_en(y_wb_en),
      .y_wb_idx(y_wb_idx), .y_wb_val(y_wb_val));

   ddsagu_ram_model ram_u (
      .core_clk(core_clk), .rstn(rstn), .x_addr(x_addr), .x_rd(x_rd),
      .x_wr_en(x_wr_en), .x_wr_data(x_wr_data), .y_addr(y_addr), .y_rd(y_rd),
      .x_q(), .y_q(), .n_bad(n_bad));

   // Compare and count
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // One Avalon transfer, held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      int n;
      @(posedge core_clk);
      {avs_address, avs_writedata, avs_write, avs_read} <= {a, d, wr, ~wr};
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (avs_waitrequest !== 1'h0 && n < 50);
      if (n >= 50) chk("bus answer", 32'h0, 32'h1);
      rd = avs_readdata;
      {avs_write, avs_read} <= 2'h0;
   endtask

   // One request per row, Y joins on word reads
   task automatic run_rows(input int lo, input int hi);
      ddsagu_tb_row_t r;
      logic dual;
      for (int k = lo; k <= hi; k++) begin
         r = rows[k];
         dual = ~r.w & ~r.b;
         @(posedge core_clk);
         {x_req, x_ptr_idx, x_am, x_wr, x_byte, x_ptr, x_ofs, x_wdata} <=
            {1'h1, r.i, r.am, r.w, r.b, r.p, r.o, r.p ^ 16'h5A5A};
         {y_req, y_ptr_idx, y_am, y_ptr, y_ofs} <= {dual, r.i, r.am, r.p, r.o};
         @(posedge core_clk);
         {x_req, y_req} <= 2'h0;
         #1;
         chk("x_addr", x_addr, r.ea);
         chk("x_rd x_wr_en", {x_rd, x_wr_en, x_byte_en}, {~r.w, r.w, r.b});
         chk("x_wb_en", x_wb_en, r.we);
         if (r.we) chk("x_wb", {x_wb_idx, x_wb_val}, {r.i, r.nv});
         if (r.w) chk("x_wr_data", x_wr_data, r.p ^ 16'h5A5A);
         chk("y_rd", y_rd, dual);
         if (dual) chk("y_addr", {y_addr, y_wb_en}, {r.ea, r.we});
         if (dual && r.we) chk("y_wb", {y_wb_idx, y_wb_val}, {r.i, r.nv});
         @(posedge core_clk);
         #1;
         chk("strobes drop", {x_rd, x_wr_en, y_rd}, 3'h0);
      end
   endtask

   // Verdict and end of run
   task automatic give_verdict;
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // Watchdog against a hung handshake
   initial begin
      #100000;
      n_fail++;
      give_verdict;
   end

   // Main sequence
   initial begin
      {avs_read, avs_write, avs_address, avs_writedata, avs_byteenable} = {2'h0, 4'h0, 32'h0, 4'hF};
      {x_req, x_ptr_idx, x_am, x_wr, x_byte, x_ptr, x_ofs, x_wdata} = '0;
      {y_req, y_ptr_idx, y_am, y_ptr, y_ofs} = '0;
      repeat (16) @(posedge core_clk);
      #1;
      chk("reset outs", {avs_waitrequest, x_rd, x_wr_en, y_rd, x_wb_en, x_addr}, 21'h100000);
      @(posedge core_clk);
      rstn <= 1'h1;
      bus(1'h0, ddsagu_pkg::REG_MODE, 32'h0);
      chk("mode reset", rd, 32'h00000FFF);
      bus(1'h0, ddsagu_pkg::REG_X_END, 32'h0);
      chk("x_end reset", rd, 32'h0000FFFF);
      bus(1'h0, ddsagu_pkg::REG_BITREV, 32'h0);
      chk("bitrev reset", rd, 32'h00000000);
      bus(1'h1, ddsagu_pkg::REG_CONFIG, 32'h00000000);
      bus(1'h0, ddsagu_pkg::REG_CONFIG, 32'h0);
      chk("config", rd, 32'h00014000);
      bus(1'h1, 4'h9, 32'h0000FFFF);
      bus(1'h0, 4'h9, 32'h0);
      chk("unmapped", rd, 32'h00000000);
      // Same circular buffer on both units, reversal off for pointer 2
      bus(1'h1, ddsagu_pkg::REG_X_START, 32'h00001000);
      bus(1'h1, ddsagu_pkg::REG_X_END, 32'h0000100F);
      bus(1'h1, ddsagu_pkg::REG_Y_START, 32'h00001000);
      bus(1'h1, ddsagu_pkg::REG_Y_END, 32'h0000100F);
      bus(1'h1, ddsagu_pkg::REG_BITREV, 32'h00008004);
      bus(1'h1, ddsagu_pkg::REG_MODE, 32'h0000CF22);
      bus(1'h0, ddsagu_pkg::REG_MODE, 32'h0);
      chk("mode write", rd, 32'h0000CF22);
      run_rows(0, 8);
      // Reversal on pointer 2 together with modulo
      bus(1'h1, ddsagu_pkg::REG_MODE, 32'h0000C222);
      run_rows(9, 9);
      bus(1'h0, ddsagu_pkg::REG_STATUS, 32'h0);
      chk("status", rd, 32'h0001100C);
      chk("ram word", ram_u.mem[16'h100C], 16'h100D ^ 16'h5A5A);
      run_rows(10, 13);
      bus(1'h1, ddsagu_pkg::REG_BITREV, 32'h00000004);
      run_rows(14, 14);
      // Y alone, pre-increment past the buffer end wraps and writes back
      @(posedge core_clk);
      {y_req, y_ptr_idx, y_am, y_ptr} <= {1'h1, 4'h2, 3'h3, 16'h100E};
      @(posedge core_clk);
      y_req <= 1'h0;
      #1;
      chk("y alone addr", {y_rd, y_addr}, {1'h1, 16'h1000});
      chk("y alone wb", {y_wb_en, y_wb_idx, y_wb_val}, {1'h1, 4'h2, 16'h1000});
      chk("y alone x idle", {x_rd, x_wr_en}, 2'h0);
      bus(1'h0, ddsagu_pkg::REG_STATUS, 32'h0);
      chk("status y", rd, 32'h000C1004);
      // Clock enable low freezes outputs and holds off the request
      @(posedge core_clk);
      ce <= 1'h0;
      {x_req, x_ptr_idx, x_am, x_wr, x_byte, x_ptr} <= {1'h1, 4'h5, 3'h0, 2'h0, 16'h0123};
      repeat (2) @(posedge core_clk);
      #1;
      chk("ce freeze", {x_rd, x_addr}, {1'h0, 16'h1004});
      @(posedge core_clk);
      ce <= 1'h1;
      @(posedge core_clk);
      x_req <= 1'h0;
      #1;
      chk("ce resume", {x_rd, x_addr}, {1'h1, 16'h0123});
      chk("ram both ways", n_bad, 32'h0);
      // Reset in mid-run brings outputs and registers back
      @(posedge core_clk);
      rstn <= 1'h0;
      @(posedge core_clk);
      #1;
      chk("mid reset", {avs_waitrequest, x_rd, y_rd, x_wb_en, x_addr}, 20'h80000);
      @(posedge core_clk);
      rstn <= 1'h1;
      bus(1'h0, ddsagu_pkg::REG_MODE, 32'h0);
      chk("mode after reset", rd, 32'h00000FFF);
      give_verdict;
   end
endmodule
